/* bench/pulse_source.sv */
`timescale 1ns/1ns
// ----
// Pulse or two-phase encoder source
// ----
module pulse_source (
	input  wire logic i_clk,
	output logic      o_a,
	output logic      o_b
);
	initial begin
		o_a = 1'h0;
		o_b = 1'h0;
	end

	// New levels after a falling edge, held n cycles
	task automatic drive(input logic a, input logic b, input int n);
		@(negedge i_clk);
		o_a = a;
		o_b = b;
		repeat (n) @(negedge i_clk);
	endtask : drive
endmodule : pulse_source

/* bench/tb.sv */
`timescale 1ns/1ns
module tb;
	import event_counter_pkg::*;
	logic        i_clk = 1'h0;
	logic        i_nrst = 1'h0;
	ctrl_t       i_ctrl = '0;
	timer_wr_t   i_timer_wr = '0;
	logic [1:0]  ovf = 2'h0;
	logic        src_a;
	logic        src_b;
	logic        i_event_output_pin;
	logic [15:0] o_count;
	logic [15:0] o_reload;
	logic [15:0] c0_count;
	logic        o_irq;
	logic        o_wrap;
	logic        o_event_output_pin;
	logic        o_event_output_pin_oe_n;
	logic [15:0] v;
	int          err_count = 0;
	int          n_compared = 0;

	always #4 i_clk = ~i_clk;
	assign i_event_output_pin = o_event_output_pin_oe_n ? src_b
		: o_event_output_pin;

	event_counter_timer #(.CHANNEL(2)) u_dut (.i_clk, .i_nrst, .i_ctrl,
		.i_timer_wr, .i_event_input_pin(src_a), .i_event_output_pin,
		.i_b_group_timer_two_ovf(ovf[0]),
		.i_neighbour_a_group_timer_ovf(ovf[1]), .o_count, .o_reload,
		.o_irq, .o_wrap, .o_event_output_pin, .o_event_output_pin_oe_n);
	event_counter_timer #(.CHANNEL(0)) u_ch0 (.i_clk, .i_nrst, .i_ctrl,
		.i_timer_wr, .i_event_input_pin(src_a),
		.i_event_output_pin(src_b), .i_b_group_timer_two_ovf(ovf[0]),
		.i_neighbour_a_group_timer_ovf(ovf[1]), .o_count(c0_count),
		.o_reload(), .o_irq(), .o_wrap(), .o_event_output_pin(),
		.o_event_output_pin_oe_n());
	pulse_source u_src (.i_clk, .o_a(src_a), .o_b(src_b));

	// ----
	// Helpers
	// ----
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask : tick

	task automatic wr(input logic [15:0] d);
		tick(1);
		i_timer_wr = '{1'h1, d};
		tick(1);
		i_timer_wr.en = 1'h0;
	endtask : wr

	task automatic pulse(input int s);
		tick(1);
		ovf[s] = 1'h1;
		tick(1);
		ovf[s] = 1'h0;
	endtask : pulse

	task automatic pin(input logic a, input logic b, input logic [15:0] e);
		u_src.drive(a, b, 4);
		chk("pin count", o_count, e);
	endtask : pin

	task automatic end_of_test;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// ----
	// Scenarios
	// ----
	task automatic t_reload;
		chk("reset count", o_count, 16'h0000);
		i_nrst = 1'h1;
		i_ctrl.mode = MODE_EVENT;
		wr(16'hFFFE);
		chk("stopped write", o_count, 16'hFFFE);
		i_ctrl.src = SRC_B_GROUP_TIMER_TWO;
		i_ctrl.dir_up = 1'h1;
		i_ctrl.pulse_out_en = 1'h1;
		i_ctrl.count_start = 1'h1;
		tick(1);
		chk("oe_n", 16'(o_event_output_pin_oe_n), 16'h0000);
		pulse(0);
		chk("up count", o_count, 16'hFFFF);
		wr(16'h0050);
		chk("run write reload", o_reload, 16'h0050);
		chk("run write count", o_count, 16'hFFFF);
		pulse(0);
		chk("reload", o_count, 16'h0050);
		chk("irq", 16'(o_irq), 16'h0001);
		chk("wrap", 16'(o_wrap), 16'h0001);
		chk("pulse pin", 16'(o_event_output_pin), 16'h0001);
		tick(1);
		chk("irq end", 16'(o_irq), 16'h0000);
	endtask : t_reload

	task automatic t_gate;
		i_ctrl.count_start = 1'h0;
		pulse(0);
		chk("stopped", o_count, 16'h0050);
		i_ctrl.count_start = 1'h1;
		i_ctrl.mode = MODE_TIMER;
		pulse(0);
		chk("mode", o_count, 16'h0050);
		i_ctrl.mode = MODE_EVENT;
		i_ctrl.src = SRC_NEIGHBOUR_A_GROUP_TIMER;
		pulse(0);
		chk("unselected", o_count, 16'h0050);
		pulse(1);
		chk("neighbour", o_count, 16'h0051);
	endtask : t_gate

	task automatic t_free_down;
		i_ctrl.count_start = 1'h0;
		wr(16'h0001);
		i_ctrl.free_run = 1'h1;
		i_ctrl.dir_up = 1'h0;
		i_ctrl.count_start = 1'h1;
		pulse(1);
		chk("down", o_count, 16'h0000);
		pulse(1);
		chk("free wrap", o_count, 16'hFFFF);
		chk("under irq", 16'(o_irq), 16'h0001);
	endtask : t_free_down

	task automatic t_pin;
		i_ctrl = '0;
		i_ctrl.mode = MODE_EVENT;
		wr(16'h0010);
		i_ctrl.in_pin_is_source = 1'h1;
		i_ctrl.dir_from_pin = 1'h1;
		i_ctrl.count_start = 1'h1;
		tick(1);
		chk("oe_n off", 16'(o_event_output_pin_oe_n), 16'h0001);
		pin(1'h1, 1'h1, 16'h0011);
		pin(1'h0, 1'h1, 16'h0011);
		i_ctrl.edge_falling = 1'h1;
		pin(1'h1, 1'h1, 16'h0011);
		pin(1'h0, 1'h1, 16'h0012);
		pin(1'h1, 1'h0, 16'h0012);
		pin(1'h0, 1'h0, 16'h0011);
	endtask : t_pin

	task automatic t_two_phase;
		i_ctrl.edge_falling = 1'h0;
		i_ctrl.dir_from_pin = 1'h0;
		i_ctrl.dir_up = 1'h1;
		i_ctrl.two_phase = 1'h1;
		v = c0_count;
		pin(1'h0, 1'h1, 16'h0011);
		pin(1'h1, 1'h1, 16'h0012);
		pin(1'h0, 1'h1, 16'h0011);
		pin(1'h0, 1'h0, 16'h0011);
		pin(1'h1, 1'h0, 16'h0011);
		chk("ch0 single", c0_count, v + 16'h0002);
	endtask : t_two_phase

	task automatic t_reset;
		i_ctrl.two_phase = 1'h0;
		i_nrst = 1'h0;
		tick(3);
		chk("rerun count", o_count, 16'h0000);
		chk("rerun reload", o_reload, 16'h0000);
		i_nrst = 1'h1;
		tick(6);
		chk("no false edge", o_count, 16'h0000);
	endtask : t_reset

	initial begin
		tick(16);
		t_reload;
		t_gate;
		t_free_down;
		t_pin;
		t_two_phase;
		t_reset;
		end_of_test;
	end

	initial begin
		#400000;
		err_count++;
		end_of_test;
	end
endmodule : tb

/* rtl/event_counter_pkg.sv */
package event_counter_pkg;

	localparam int unsigned CNT_W       = 16;
	localparam logic [15:0] CNT_ZERO    = 16'h0000;
	localparam logic [15:0] CNT_ONES    = 16'hFFFF;
	localparam logic [15:0] CNT_STEP    = 16'h0001;
	localparam logic [15:0] RELOAD_RST  = 16'h0000;
	localparam logic [1:0]  MODE_TIMER  = 2'h0;
	localparam logic [1:0]  MODE_EVENT  = 2'h1;
	localparam int unsigned FIRST_2PH   = 2;
	localparam int unsigned SYNC_FILL   = 3;

	typedef enum logic [1:0] {
		SRC_PIN,
		SRC_B_GROUP_TIMER_TWO,
		SRC_NEIGHBOUR_A_GROUP_TIMER
	} count_src_t;

	// Mode register bits 0 and 1 plus the event counter controls
	typedef struct packed {
		logic [1:0] mode;
		logic       count_start;
		logic       free_run;
		logic       two_phase;
		logic       edge_falling;
		count_src_t src;
		logic       in_pin_is_source;
		logic       dir_from_pin;
		logic       dir_up;
		logic       pulse_out_en;
	} ctrl_t;

	typedef struct packed {
		logic        en;
		logic [15:0] data;
	} timer_wr_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic [SYNC_FILL-1:0] live;
	} sync_state_t;

endpackage : event_counter_pkg

/* rtl/event_counter_timer.sv */
// Function
// R1: Counter steps on external pin events or internal timer overflows.
// R2: Channels zero and one count single-phase only, never two-phase.
// R3: Channels two to four count single-phase or two-phase signals.
// R4: Active edge of the event input pin is software selectable.
// R5: Count source may be B-group timer two or neighbour overflow.
// R6: Single-phase direction from software bit or direction pin level.
// R7: Without free-run, overflow or underflow loads the reload value.
// R8: Wrap period is FFFF minus n plus one up, n plus one down.
// R9: Counting runs while count start is 1, halts while 0.
// R10: Interrupt request on every overflow or underflow.
// R11: Event input pin is a port pin or the count source input.
// R12: Event output pin is port pin, pulse output or direction input.
// R13: Reading the timer returns the current counter value.
// R14: Write while stopped loads both reload register and counter.
// R15: Write while counting loads reload only, counter at next reload.
// R16: Free-run wraps on overflow or underflow without reloading.
// R17: Pulse output toggles the output pin on every wrap.
// R18: Two-phase mode takes pulses on both event pins.
// R19: Two-phase direction comes from the phase of the two signals.
// R20: Two-phase: rise counts up, fall counts down, output pin high.
// R21: Counter and reload register are sixteen bits wide.
// R22: Mode register bits 0 and 1 select the operating mode.
// R23: Overflow and underflow are each a single-cycle event.
// R24: Pin inputs pass two flip-flops before edge detection.
`timescale 1ns/1ns
module event_counter_timer #(
	parameter int unsigned CHANNEL = 2
) (
	input  wire logic                      i_clk,
	input  wire logic                      i_nrst,
	input  event_counter_pkg::ctrl_t       i_ctrl,
	input  event_counter_pkg::timer_wr_t   i_timer_wr,
	input  wire logic                      i_event_input_pin,
	input  wire logic                      i_event_output_pin,
	input  wire logic                      i_b_group_timer_two_ovf,
	input  wire logic                      i_neighbour_a_group_timer_ovf,
	output logic [15:0]                    o_count,
	output logic [15:0]                    o_reload,
	output logic                           o_irq,
	output logic                           o_wrap,
	output logic                           o_event_output_pin,
	output logic                           o_event_output_pin_oe_n
);
	import event_counter_pkg::*;

	localparam bit TWO_PHASE_OK = (CHANNEL >= FIRST_2PH);

	typedef struct packed {
		logic [CNT_W-1:0] counter;
		logic [CNT_W-1:0] reload;
		logic             out_level;
		logic             irq;
		logic             wrap;
	} state_t;

	state_t st_reg;
	state_t st_next;

	logic in_level;
	logic in_rise;
	logic in_fall;
	logic out_level_in;
	logic out_rise;
	logic out_fall;
	logic counting;
	logic tp_active;
	logic pin_edge;
	logic src_event;
	logic dir_up;
	logic step_up;
	logic step_dn;
	logic ovf;
	logic unf;
	logic wrap;
	logic drive_out;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	pin_edge_sync u_in_sync ( // R24
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_pin   (i_event_input_pin),
		.o_level (in_level),
		.o_rise  (in_rise),
		.o_fall  (in_fall)
	);

	pin_edge_sync u_out_sync (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_pin   (i_event_output_pin),
		.o_level (out_level_in),
		.o_rise  (out_rise),
		.o_fall  (out_fall)
	);

	// ------------------------------------------------------------
	// Count event selection
	// ------------------------------------------------------------
	assign counting  = (i_ctrl.mode == MODE_EVENT) &&
	                   i_ctrl.count_start; // R9 R22
	assign tp_active = TWO_PHASE_OK && i_ctrl.two_phase; // R2 R3
	assign pin_edge  = i_ctrl.edge_falling ? in_fall : in_rise; // R4

	always_comb begin
		unique case (i_ctrl.src)
			SRC_PIN:
				src_event = i_ctrl.in_pin_is_source && pin_edge; // R11
			SRC_B_GROUP_TIMER_TWO:
				src_event = i_b_group_timer_two_ovf; // R5
			SRC_NEIGHBOUR_A_GROUP_TIMER:
				src_event = i_neighbour_a_group_timer_ovf; // R5
			default:
				src_event = 1'b0;
		endcase
	end

	// Direction pin high counts up
	assign dir_up = i_ctrl.dir_from_pin ? out_level_in
	                                    : i_ctrl.dir_up; // R6 R12

	always_comb begin
		if (tp_active) begin
			// Phase of the two pins sets the direction
			step_up = counting && in_rise && out_level_in; // R18 R19 R20
			step_dn = counting && in_fall && out_level_in; // R20
		end else begin
			step_up = counting && src_event && dir_up; // R1
			step_dn = counting && src_event && !dir_up; // R1
		end
	end

	assign ovf  = step_up && (st_reg.counter == CNT_ONES); // R23
	assign unf  = step_dn && (st_reg.counter == CNT_ZERO); // R23
	assign wrap = ovf || unf;

	// ------------------------------------------------------------
	// Counter, reload and pulse output
	// ------------------------------------------------------------
	always_comb begin
		st_next      = st_reg;
		st_next.irq  = wrap; // R10
		st_next.wrap = wrap;
		if (i_timer_wr.en) begin
			st_next.reload = i_timer_wr.data; // R14 R15
			if (!counting) begin
				st_next.counter = i_timer_wr.data; // R14
			end
		end
		if (wrap) begin
			if (i_ctrl.free_run) begin
				st_next.counter = ovf ? CNT_ZERO : CNT_ONES; // R16
			end else begin
				st_next.counter = st_next.reload; // R7 R8 R15
			end
		end else if (step_up) begin
			st_next.counter = st_reg.counter + CNT_STEP; // R1
		end else if (step_dn) begin
			st_next.counter = st_reg.counter - CNT_STEP; // R1
		end
		if (!i_ctrl.pulse_out_en) begin
			st_next.out_level = 1'b0;
		end else if (wrap) begin
			st_next.out_level = ~st_reg.out_level; // R17
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			st_reg <= '{counter: CNT_ZERO, reload: RELOAD_RST,
			            default: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Pin is released whenever it serves as an input
	assign drive_out = i_ctrl.pulse_out_en && !i_ctrl.dir_from_pin &&
	                   !tp_active; // R12
	assign o_event_output_pin      = st_reg.out_level;
	assign o_event_output_pin_oe_n = !drive_out; // R12 R17
	assign o_count                 = st_reg.counter; // R13 R21
	assign o_reload                = st_reg.reload; // R21
	assign o_irq                   = st_reg.irq; // R10
	assign o_wrap                  = st_reg.wrap;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	sequence pin_rise_s;
		$rose(i_event_input_pin) ##1 i_event_input_pin;
	endsequence

	sequence wrap_s;
		wrap && !i_ctrl.free_run;
	endsequence

	sequence pin_fall_s;
		$fell(i_event_input_pin) ##1 !i_event_input_pin;
	endsequence

	sequence out_rise_s;
		$rose(i_event_output_pin) ##1 i_event_output_pin;
	endsequence

	irq_on_wrap_a: assert property ( // R10
		wrap |=> o_irq ##1 (!o_irq || $past(wrap)))
		else $error("wrap did not give one irq pulse");

	irq_cause_a: assert property ( // R23
		o_irq |-> $past(ovf) || $past(unf))
		else $error("irq without overflow or underflow");

	stop_hold_a: assert property ( // R9
		!counting && !i_timer_wr.en |=> $stable(o_count))
		else $error("counter moved while stopped");

	up_step_a: assert property ( // R1
		step_up && !wrap |=> o_count == $past(o_count) + CNT_STEP)
		else $error("up count step wrong");

	down_step_a: assert property ( // R1
		step_dn && !wrap |=> o_count == $past(o_count) - CNT_STEP)
		else $error("down count step wrong");

	reload_wrap_a: assert property ( // R7
		wrap_s |=> o_count == o_reload)
		else $error("wrap did not load reload value");

	free_ovf_a: assert property ( // R16
		ovf && i_ctrl.free_run |=> o_count == CNT_ZERO)
		else $error("free-run overflow not zero");

	free_unf_a: assert property ( // R16
		unf && i_ctrl.free_run |=> o_count == CNT_ONES)
		else $error("free-run underflow not all ones");

	stopped_write_a: assert property ( // R14
		i_timer_wr.en && !counting |=>
		o_count == $past(i_timer_wr.data) &&
		o_reload == $past(i_timer_wr.data))
		else $error("stopped write did not load both");

	running_write_a: assert property ( // R15
		i_timer_wr.en && counting && !step_up && !step_dn |=>
		o_count == $past(o_count) &&
		o_reload == $past(i_timer_wr.data))
		else $error("running write touched counter");

	pulse_toggle_a: assert property ( // R17
		wrap && i_ctrl.pulse_out_en |=>
		o_event_output_pin != $past(o_event_output_pin))
		else $error("pulse output did not toggle");

	no_two_phase_a: assert property ( // R2
		(CHANNEL < FIRST_2PH) && i_ctrl.two_phase |->
		step_up == (counting && src_event && dir_up))
		else $error("two-phase active on low channel");

	phase_up_a: assert property ( // R20
		tp_active && counting && in_rise && out_level_in && !wrap |=>
		o_count == $past(o_count) + CNT_STEP)
		else $error("two-phase rise did not count up");

	phase_dn_a: assert property ( // R19
		tp_active && counting && in_fall && out_level_in && !wrap |=>
		o_count == $past(o_count) - CNT_STEP)
		else $error("two-phase fall did not count down");

	edge_sync_a: assert property ( // R24
		pin_rise_s |-> ##1 in_rise ##1 !in_rise)
		else $error("synchronised edge not one pulse");

	edge_select_a: assert property ( // R4
		counting && !tp_active && i_ctrl.src == SRC_PIN &&
		i_ctrl.in_pin_is_source && i_ctrl.edge_falling && in_rise
		|-> !step_up && !step_dn)
		else $error("wrong edge counted");

	mode_gate_a: assert property ( // R22
		i_ctrl.mode != MODE_EVENT |-> !step_up && !step_dn)
		else $error("counted outside event counter mode");

	oe_input_a: assert property ( // R12
		i_ctrl.dir_from_pin || tp_active |-> o_event_output_pin_oe_n)
		else $error("output pin driven while input");

	phase_low_a: assert property ( // R19
		tp_active && !out_level_in |-> !step_up && !step_dn)
		else $error("two-phase counted with output pin low");

	single_up_a: assert property ( // R3
		!tp_active && counting && src_event && dir_up && !wrap |=>
		o_count == $past(o_count) + CNT_STEP)
		else $error("single-phase up step wrong");

	dir_pin_a: assert property ( // R6
		counting && !tp_active && i_ctrl.dir_from_pin && src_event &&
		!out_level_in |-> step_dn && !step_up)
		else $error("direction pin low did not count down");

	pin_source_a: assert property ( // R11
		!tp_active && i_ctrl.src == SRC_PIN &&
		!i_ctrl.in_pin_is_source |-> !step_up && !step_dn)
		else $error("port pin counted as source");

	wrap_flag_a: assert property ( // R23
		wrap |=> o_wrap)
		else $error("wrap flag missing");

	wrap_clear_a: assert property ( // R23
		!wrap |=> !o_wrap)
		else $error("wrap flag without wrap");

	run_write_wrap_a: assert property ( // R15
		i_timer_wr.en && wrap && !i_ctrl.free_run |=>
		o_count == $past(i_timer_wr.data))
		else $error("reload at wrap missed new value");

	pulse_off_a: assert property ( // R17
		!i_ctrl.pulse_out_en |=> !o_event_output_pin)
		else $error("pulse level kept while disabled");

	pulse_hold_a: assert property ( // R17
		!wrap && i_ctrl.pulse_out_en |=> $stable(o_event_output_pin))
		else $error("pulse output moved without wrap");

	reload_hold_a: assert property ( // R15
		!i_timer_wr.en |=> $stable(o_reload))
		else $error("reload changed without write");

	stopped_step_a: assert property ( // R9
		!counting |-> !step_up && !step_dn)
		else $error("step while stopped");

	edge_fall_sync_a: assert property ( // R24
		pin_fall_s |-> ##1 in_fall ##1 !in_fall)
		else $error("synchronised fall not one pulse");

	out_edge_a: assert property ( // R18
		out_rise_s |-> ##1 out_rise ##1 !out_rise)
		else $error("output pin rise not one pulse");

	in_edge_level_a: assert property ( // R24
		in_rise |-> in_level)
		else $error("rise seen with input level low");

endmodule : event_counter_timer

/* rtl/pin_edge_sync.sv */
`timescale 1ns/1ns
module pin_edge_sync (
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	import event_counter_pkg::*;

	sync_state_t st_reg;
	sync_state_t st_next;

	always_comb begin
		st_next      = st_reg;
		st_next.s1   = i_pin;
		st_next.s2   = st_reg.s1;
		st_next.prev = st_reg.s2;
		st_next.live = {st_reg.live[SYNC_FILL-2:0], 1'b1};
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_level = st_reg.s2;
	// No edges until prev holds a real pin sample
	assign o_rise  = st_reg.live[SYNC_FILL-1] & st_reg.s2 & ~st_reg.prev; // R24
	assign o_fall  = st_reg.live[SYNC_FILL-1] & ~st_reg.s2 & st_reg.prev; // R24

endmodule : pin_edge_sync
